/* src/sllsl_pkg.sv */
/*
  Package for the serial LED shift-and-latch front end: widths, reset values and carried structs.
  Assumes a single system clock; serial pins arrive asynchronously and are synchronised in the top.
*/
package sllsl_pkg;
  localparam int unsigned WORD_W     = 8;
  localparam logic [7:0]  SHIFT_RST  = 8'h00;
  localparam logic [7:0]  LATCH_RST  = 8'h00;
  localparam logic [7:0]  SINK_OFF   = 8'h00;
  localparam logic [7:0]  SINK_HIZ   = 8'hFF;
  localparam logic [2:0]  SYNC_RST   = 3'h0;

  // Serial pins, sampled as one group
  typedef struct packed {
    logic ser_clk;
    logic ser_din;
    logic load_strobe;
    logic out_en_n;
  } sllsl_pins_s;

  // Driven LED sink outputs: on-level and enable, both per output
  typedef struct packed {
    logic [7:0] sink_o;
    logic [7:0] sink_oe_n;
  } sllsl_sink_s;
endpackage

/* src/sllsl_latch.sv */
/*
  Output latch of the LED front end: transparent while load is high, held while low.
  Assumes its inputs are already synchronised and arrive on clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
module sllsl_latch
  import sllsl_pkg::*;
(
  input  wire logic             clk_sys,      // System clock
  input  wire logic             rst_n,        // Synchronous reset
  input  wire logic             clk_en,       // Freezes state when low
  input  wire logic             load_strobe,  // Synchronised load level
  input  wire logic [WORD_W-1:0] shift_val,   // Shift register contents
  output logic      [WORD_W-1:0] word_bits    // Latched word
);
  typedef struct packed {
    logic [WORD_W-1:0] word;
  } sllsl_lstate_s;

  sllsl_lstate_s state_ff;
  sllsl_lstate_s nxt_state;

  always_comb begin
    nxt_state = state_ff;
    if (load_strobe) begin
      nxt_state.word = shift_val;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_ff.word <= LATCH_RST;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  assign word_bits = state_ff.word;

  a_latch_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && !load_strobe) |=> $stable(word_bits))
    else $error("latch changed while load low");

  a_latch_follows: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && load_strobe) |=> (word_bits == $past(shift_val)))
    else $error("latch not transparent while load high");
endmodule
`default_nettype wire

/* src/sllsl_top.sv */
/*
  Serial front end of an eight-output LED sink driver: shift register, output latch, blanking.
  Assumes all serial pins are asynchronous to clk_sys, which must oversample the serial clock.
*/
`timescale 1ns/1ns
`default_nettype none
module sllsl_top
  import sllsl_pkg::*;
(
  input  wire logic              clk_sys,    // System clock, 100 MHz
  input  wire logic              rst_n,      // Synchronous reset, active low
  input  wire logic              clk_en,     // Freezes all state when low
  input  wire sllsl_pins_s       pins,       // Asynchronous serial pins
  output logic                   ser_dout,   // Serial data out, registered
  output logic      [WORD_W-1:0] led_sink,   // Sink level, low pulls LED on
  output logic      [WORD_W-1:0] led_sink_oe_n // Sink enable, low drives
);
  typedef struct packed {
    sllsl_pins_s       sync1;
    sllsl_pins_s       sync2;
    logic              clk_prev;
    logic [WORD_W-1:0] shift;
    logic              dout;
    sllsl_sink_s       sink;
    // Serial rises since reset, saturating; read only by the checks
    logic [3:0]        rises;
  } sllsl_state_s;

  sllsl_state_s      state_ff;
  sllsl_state_s      nxt_state;
  logic [WORD_W-1:0] word_bits;
  logic              clk_rise;
  logic [WORD_W-1:0] lit_n;

  assign clk_rise = state_ff.sync2.ser_clk && !state_ff.clk_prev;

  always_comb begin
    nxt_state          = state_ff;
    nxt_state.sync1    = pins;
    nxt_state.sync2    = state_ff.sync1;
    nxt_state.clk_prev = state_ff.sync2.ser_clk;
    // Enable is not consulted here so blanking never disturbs data
    if (clk_rise) begin
      nxt_state.shift = {state_ff.shift[WORD_W-2:0], state_ff.sync2.ser_din};
      nxt_state.dout  = state_ff.shift[WORD_W-1];
    end
    // Saturates so the count stays four bits wide
    if (clk_rise && state_ff.rises != 4'(WORD_W)) begin
      nxt_state.rises = state_ff.rises + 4'h1;
    end
    // Open drain: a one in the latch pulls the pin low
    nxt_state.sink.sink_o = lit_n;
    if (state_ff.sync2.out_en_n) begin
      nxt_state.sink.sink_oe_n = SINK_HIZ;
    end else begin
      nxt_state.sink.sink_oe_n = lit_n;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_ff.sync1          <= '0;
      state_ff.sync2          <= '0;
      state_ff.clk_prev       <= 1'b0;
      state_ff.shift          <= SHIFT_RST;
      state_ff.dout           <= 1'b0;
      state_ff.sink.sink_o    <= SINK_OFF;
      state_ff.sink.sink_oe_n <= SINK_HIZ;
      state_ff.rises          <= 4'h0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  sllsl_latch u_latch (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .clk_en      (clk_en),
    .load_strobe (state_ff.sync2.load_strobe),
    .shift_val   (state_ff.shift),
    .word_bits   (word_bits)
  );

  // One sink per output; a latch one lights it, blanking overrides
  for (genvar g = 0; g < WORD_W; g++) begin : g_out
    assign lit_n[g] = ~word_bits[g];

    a_bit_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clk_en && !state_ff.sync2.out_en_n) |=> (led_sink_oe_n[g] == !$past(word_bits[g])))
      else $error("output bit does not follow its latch bit");

    a_bit_blank: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clk_en && state_ff.sync2.out_en_n) |=> led_sink_oe_n[g])
      else $error("output bit driven while blanked");
  end

  assign ser_dout      = state_ff.dout;
  assign led_sink      = state_ff.sink.sink_o;
  assign led_sink_oe_n = state_ff.sink.sink_oe_n;

  a_shift_in: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && clk_rise) |=> (state_ff.shift == {$past(state_ff.shift[6:0]), $past(state_ff.sync2.ser_din)}))
    else $error("shift register did not take serial input");

  a_dout_last: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && clk_rise) |=> (ser_dout == $past(state_ff.shift[7])))
    else $error("serial out not from last stage");

  a_dout_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && !clk_rise) |=> $stable(ser_dout))
    else $error("serial out moved without clock edge");

  a_blank_hiz: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && state_ff.sync2.out_en_n) |=> (led_sink_oe_n == 8'hFF))
    else $error("outputs not blanked");

  a_sink_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && !state_ff.sync2.out_en_n) |=> (led_sink_oe_n == ~$past(word_bits)))
    else $error("sink does not follow latch");

  a_reset_state: assert property (@(posedge clk_sys)
    !rst_n |=> (ser_dout == 1'b0 && led_sink_oe_n == 8'hFF && word_bits == 8'h00))
    else $error("reset state wrong");

  a_enable_free: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && clk_rise && state_ff.sync2.out_en_n) |=> (state_ff.shift[0] == $past(state_ff.sync2.ser_din)))
    else $error("shifting blocked by enable");

  // Pin sampling: two flops, no cycle skipped
  a_sync_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en |=> (state_ff.sync1 == $past(pins)))
    else $error("first sync stage missed the pins");

  a_sync_chain: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en |=> (state_ff.sync2 == $past(state_ff.sync1)))
    else $error("second sync stage missed the first");

  a_prev_track: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en |=> (state_ff.clk_prev == $past(state_ff.sync2.ser_clk)))
    else $error("edge detector lost the clock level");

  a_reset_noedge: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(rst_n) |-> !clk_rise)
    else $error("serial edge seen right after reset");

  // Clock enable low freezes every flop, synchronisers too
  a_frozen_state: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!clk_en) |=> ($stable(state_ff) && $stable(word_bits)))
    else $error("state moved while clock enable low");

  // Until eight rises have passed only reset zeros can leave
  a_dout_fill: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && clk_rise && state_ff.rises < 4'(WORD_W)) |=> !ser_dout)
    else $error("serial out high before eight rises");

  a_dout_on_rise: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($past(rst_n) && $changed(ser_dout)) |-> ($past(clk_rise) && $past(clk_en)))
    else $error("serial out changed without a rise");

  a_dout_enfree: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && clk_rise && state_ff.sync2.out_en_n) |=> (ser_dout == $past(state_ff.shift[7])))
    else $error("serial out blocked by enable");

  a_load_no_dout: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && state_ff.sync2.load_strobe && !clk_rise) |=> $stable(ser_dout))
    else $error("load disturbed serial out");

  a_shift_on_rise: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($past(rst_n) && !$stable(state_ff.shift)) |-> ($past(clk_rise) && $past(clk_en)))
    else $error("shift register moved without a rise");

  a_shift_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && !clk_rise) |=> $stable(state_ff.shift))
    else $error("shift register moved while idle");

  a_rise_sat: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_ff.rises <= 4'(WORD_W))
    else $error("rise count past saturation");

  // Latch and sink outputs
  a_word_on_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($past(rst_n) && !$stable(word_bits)) |-> ($past(state_ff.sync2.load_strobe) && $past(clk_en)))
    else $error("latch changed without load");

  a_latch_enfree: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && state_ff.sync2.load_strobe && state_ff.sync2.out_en_n) |=> word_bits == $past(state_ff.shift))
    else $error("latch blocked by enable");

  a_oe_no_latch: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && !state_ff.sync2.load_strobe && $changed(state_ff.sync2.out_en_n)) |=> $stable(word_bits))
    else $error("enable change altered the latch");

  a_oe_on_enable: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($past(rst_n) && !$stable(led_sink_oe_n)) |-> $past(clk_en))
    else $error("sink enable moved while frozen");

  a_reset_regs: assert property (@(posedge clk_sys)
    !rst_n |=> (state_ff.shift == SHIFT_RST && led_sink == SINK_OFF))
    else $error("reset left shift or sink level");

  a_sink_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en |=> (led_sink == ~$past(word_bits)))
    else $error("sink level does not match latch");

  a_unlit_hiz: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en |=> ((led_sink_oe_n | $past(word_bits)) == 8'hFF))
    else $error("unlit output driven");

  a_drive_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (led_sink & ~led_sink_oe_n) == 8'h00)
    else $error("driven output not pulled low");
endmodule
`default_nettype wire

/* verification/sllsl_host.sv */
/*
  Host controller model: drives the serial, load and enable pins of the LED front end.
  Assumes the caller enters each task just after a rising clk_sys edge.
*/
`timescale 1ns/1ns
`default_nettype none
module sllsl_host
  import sllsl_pkg::*;
(
  input  wire logic        clk_sys, // System clock
  output var  sllsl_pins_s pins     // Pins toward the device
);
  initial pins = 4'h1;

  // Four-cycle phases keep data stable around the rise
  task automatic bit_out(input logic b);
    pins.ser_din <= b;
    repeat (4) @(posedge clk_sys);
    pins.ser_clk <= 1'b1;
    repeat (4) @(posedge clk_sys);
    pins.ser_clk <= 1'b0;
    pins.ser_din <= ~b; // Hold over, data no longer valid
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic word_out(input logic [7:0] w);
    for (int i = 7; i >= 0; i--) begin
      bit_out(w[i]);
    end
  endtask

  task automatic set_load(input logic v);
    pins.load_strobe <= v;
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic set_oe(input logic v);
    pins.out_en_n <= v;
    @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

/* verification/tb_serial_led_shift_latch.sv */
/*
  Self-checking bench of the LED shift-and-latch front end.
  Assumes the host model is the only driver of the serial pins.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_serial_led_shift_latch;
  import sllsl_pkg::*;
  logic              clk_sys;
  logic              rst_n;
  logic              clk_en;
  sllsl_pins_s       pins;
  logic              ser_dout;
  logic [WORD_W-1:0] led_sink;
  logic [WORD_W-1:0] led_sink_oe_n;
  int                error_cnt = 0;
  int                n_compared = 0;

  sllsl_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .pins(pins),
    .ser_dout(ser_dout), .led_sink(led_sink), .led_sink_oe_n(led_sink_oe_n));
  sllsl_host u_host (.clk_sys(clk_sys), .pins(pins));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic settle;
    repeat (8) @(posedge clk_sys);
  endtask

  task automatic final_report;
    $display("errors=%0d compared=%0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic t_reset;
    check({7'h00, ser_dout}, 8'h00);
    check(led_sink_oe_n, 8'hFF);
    check(led_sink, 8'hFF);
  endtask

  task automatic t_blank;
    u_host.word_out(8'hA5);
    u_host.set_load(1'b1);
    u_host.set_load(1'b0);
    settle();
    check(led_sink_oe_n, 8'hFF);
    u_host.set_oe(1'b0);
    settle();
    check(led_sink_oe_n, 8'h5A);
    check(led_sink, 8'h5A);
  endtask

  // Old word must leave MSB first while latch holds
  task automatic t_shift_out;
    logic [7:0] w = 8'hA5;
    for (int i = 7; i >= 0; i--) begin
      u_host.bit_out(1'b0);
      check({7'h00, ser_dout}, {7'h00, w[i]});
    end
    check(led_sink_oe_n, 8'h5A);
  endtask

  task automatic t_transparent;
    u_host.set_load(1'b1);
    u_host.word_out(8'h0F);
    settle();
    check(led_sink_oe_n, 8'hF0);
    u_host.set_load(1'b0);
    u_host.word_out(8'hFF);
    u_host.set_oe(1'b1);
    settle();
    check(led_sink_oe_n, 8'hFF);
    u_host.set_oe(1'b0);
    settle();
    check(led_sink_oe_n, 8'hF0);
  endtask

  // Frozen block misses pin activity; the latch keeps its word
  task automatic t_freeze;
    clk_en <= 1'b0;
    u_host.set_oe(1'b1);
    u_host.set_load(1'b1);
    u_host.set_load(1'b0);
    settle();
    check(led_sink_oe_n, 8'hF0);
    u_host.set_oe(1'b0);
    clk_en <= 1'b1;
    settle();
    check(led_sink_oe_n, 8'hF0);
  endtask

  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    settle();
    t_reset();
    t_blank();
    t_shift_out();
    t_transparent();
    t_freeze();
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    // Second edge shows what the first edge after release launched
    repeat (2) @(posedge clk_sys);
    t_reset();
    settle();
    check(led_sink_oe_n, 8'hFF);
    u_host.bit_out(1'b0);
    check({7'h00, ser_dout}, 8'h00);
    final_report();
  end

  // About ten times the expected run
  initial begin
    repeat (5000) @(posedge clk_sys);
    error_cnt++;
    final_report();
  end
endmodule
`default_nettype wire
